// [hw/lpm_consts.svh]
// constants for the low power mode controller
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

// wake source vector layout
`define WK_W          13
`define WK_RADIO      0
`define WK_BOR        1
`define WK_PVD        2
`define WK_RTC        3
`define WK_INDEPENDENT_WATCHDOG       4
`define WK_SERIAL     5
`define WK_I2C        6
`define WK_LPTIM1     7
`define WK_LPTIM2     8
`define WK_RST_PIN    9
`define WK_ANY_IO     10
`define WK_PIN0       11
`define WK_PIN1       12

// per-mode wake masks
`define WKM_NONE      13'h0000
`define WKM_SLEEP     13'h1fff
`define WKM_STOP01    13'h07ff
`define WKM_DEEPEST_STOP_LEVEL     13'h069f
`define WKM_STANDBY   13'h1a1b
`define WKM_SHUTDOWN  13'h1808

// peripherals that may ask for the on-demand oscillator
`define OSC_REQ_W     2
`define OSC_FEED_NONE 2'h0

// wake latency in clock cycles
`define TMR_W         8
`define WAKE_SLEEP_CYC 8'h09
`define WAKE_DEEP_CYC  8'h10
`define TMR_ONE       8'h01
`define TMR_ZERO      8'h00

`endif

// [hw/lpm_pkg.sv]
// types of the low power mode controller
package lpm_pkg;

	// power modes, ordered from shallowest to deepest
	typedef enum logic [3:0] {
		M_RUN      = 4'b0000,
		M_LOW_POWER_RUN    = 4'b0001,
		M_SLEEP    = 4'b0010,
		M_LOW_POWER_SLEEP  = 4'b0011,
		M_STOP0    = 4'b0100,
		M_STOP1    = 4'b0101,
		M_DEEPEST_STOP_LEVEL    = 4'b0110,
		M_STANDBY  = 4'b0111,
		M_SHUTDOWN = 4'b1000
	} mode_t;

	// sequencer states
	typedef enum logic [1:0] {
		ST_ACTIVE = 2'b00,
		ST_LOW    = 2'b01,
		ST_WAKE   = 2'b10
	} st_t;

	// i/o pull held in standby and shutdown
	typedef enum logic [1:0] {
		PULL_FLOAT = 2'b00,
		PULL_UP    = 2'b01,
		PULL_DOWN  = 2'b10
	} pull_t;

endpackage : lpm_pkg

// [hw/wake_timer.sv]
// down counter that times the wake-up latency
`timescale 1ns/1ps
`include "lpm_consts.svh"

module wake_timer (
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic              load,
	input  wire logic [`TMR_W-1:0] load_val,
	output logic                   done
);
	logic [`TMR_W-1:0] cnt_ff;  // cycles left
	logic [`TMR_W-1:0] nxt_cnt;

	// reload on request, otherwise count down to zero
	always_comb begin
		nxt_cnt = cnt_ff;
		if (load) begin
			nxt_cnt = load_val;
		end else if (cnt_ff != `TMR_ZERO) begin
			nxt_cnt = cnt_ff - `TMR_ONE;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cnt_ff <= `TMR_ZERO;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	// last cycle of the count
	assign done = (cnt_ff == `TMR_ONE);

	chk_timer_span: assert property (@(posedge clock) disable iff (!rst_b)
		(load && load_val == (`WAKE_SLEEP_CYC - `TMR_ONE)) |->
		!done [*8] ##1 done)
		else $error("wake timer span wrong");

endmodule : wake_timer

// [hw/low_power_mode_controller.sv]
// power mode sequencer: entry, wake-up, memories, clocks, pulls
`timescale 1ns/1ps
`include "lpm_consts.svh"

module low_power_mode_controller (
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire logic                  host_mode_valid,
	input  wire lpm_pkg::mode_t        host_mode_req,
	input  wire lpm_pkg::mode_t        radio_mode_req,
	input  wire logic                  radio_active,
	input  wire logic                  radio_txrx_need,
	input  wire logic                  irq_any,
	input  wire logic [`WK_W-1:0]      wake_src,
	input  wire logic                  serial_start_bit,
	input  wire logic                  serial_addr_match,
	input  wire logic                  serial_frame_done,
	input  wire logic                  i2c_addr_match,
	input  wire logic [`OSC_REQ_W-1:0] osc_req,
	input  wire logic                  sram_retain_select,
	input  wire logic                  flash_pd_cfg,
	input  wire logic                  main_sram_clk_gate,
	input  wire logic                  second_sram_clk_gate,
	input  wire lpm_pkg::pull_t        io_pull_cfg,
	input  wire logic                  flash_prog_req,
	output lpm_pkg::mode_t             power_mode,
	output logic                       host_core_halted,
	output logic                       regulator_low_power,
	output logic                       periph_frozen,
	output logic                       lptim2_enabled,
	output logic                       flash_powered,
	output logic                       main_sram_bank_pwr,
	output logic                       retained_sram_bank_pwr,
	output logic                       auxiliary_sram_bank_pwr,
	output logic                       main_sram_clk_en,
	output logic                       second_sram_clk_en,
	output logic                       radio_crystal_osc_en,
	output logic                       on_demand_internal_osc_en,
	output logic [`OSC_REQ_W-1:0]      osc_feed,
	output logic [`WK_W-1:0]           wake_enable,
	output logic                       serial_wake_irq,
	output logic                       i2c_wake_irq,
	output lpm_pkg::pull_t             io_pull_hold,
	output logic                       flash_prog_ack,
	output logic                       flash_prog_refused
);
	import lpm_pkg::*;

	// sleep or low-power sleep: core halted, peripherals run
	function automatic logic is_sleep(input mode_t m);
		is_sleep = (m == M_SLEEP) || (m == M_LOW_POWER_SLEEP);
	endfunction : is_sleep

	// stop levels that keep every wake source but the two wake pins
	function automatic logic is_stop01(input mode_t m);
		is_stop01 = (m == M_STOP0) || (m == M_STOP1);
	endfunction : is_stop01

	// wake sources honoured in each mode
	function automatic logic [`WK_W-1:0] wake_mask(input mode_t m);
		case (m)
			M_SLEEP, M_LOW_POWER_SLEEP: wake_mask = `WKM_SLEEP;
			M_STOP0, M_STOP1:   wake_mask = `WKM_STOP01;
			M_DEEPEST_STOP_LEVEL:            wake_mask = `WKM_DEEPEST_STOP_LEVEL;
			M_STANDBY:          wake_mask = `WKM_STANDBY;
			M_SHUTDOWN:         wake_mask = `WKM_SHUTDOWN;
			default:            wake_mask = `WKM_NONE;
		endcase
	endfunction : wake_mask

	// sequencer and mode
	st_t   st_ff;          // sequencer state
	st_t   nxt_st;
	mode_t mode_ff;        // mode in force
	mode_t nxt_mode;
	mode_t target;         // arbitrated entry target
	logic  tmr_load;       // start wake latency count
	logic  tmr_done;       // wake latency elapsed
	logic  wake_hit;       // enabled wake source seen
	logic [`TMR_W-1:0] tmr_val;
	logic [`WK_W-1:0]  wk_all;  // wake sources incl. internal events

	// serial and i2c wake events join the external sources
	always_comb begin
		wk_all = wake_src;
		wk_all[`WK_SERIAL] = serial_start_bit | serial_addr_match |
			serial_frame_done;
		wk_all[`WK_I2C] = i2c_addr_match;
	end

	// shallower request wins; radio in use caps the depth
	always_comb begin
		target = (host_mode_req < radio_mode_req) ? host_mode_req :
			radio_mode_req;
		if (radio_active && target > M_DEEPEST_STOP_LEVEL) begin
			target = M_DEEPEST_STOP_LEVEL;
		end
	end

	// any interrupt also wakes from the sleep modes
	assign wake_hit = (st_ff == ST_LOW) &&
		((|(wk_all & wake_mask(mode_ff))) ||
		(is_sleep(mode_ff) && irq_any));

	// sleep wakes in a fixed short time, deeper modes take longer
	assign tmr_val = is_sleep(mode_ff) ? (`WAKE_SLEEP_CYC - `TMR_ONE) :
		(`WAKE_DEEP_CYC - `TMR_ONE);

	// entry from run, wake count, return to run
	always_comb begin
		nxt_st   = st_ff;
		nxt_mode = mode_ff;
		tmr_load = 1'b0;
		case (st_ff)
			ST_ACTIVE: begin
				if (host_mode_valid) begin
					// standby entry with radio active is capped at the deepest stop level
					nxt_mode = target;
					if (target > M_LOW_POWER_RUN) begin
						nxt_st = ST_LOW;
					end
				end
			end
			ST_LOW: begin
				if (wake_hit) begin
					nxt_st   = ST_WAKE;
					tmr_load = 1'b1;
				end
			end
			ST_WAKE: begin
				if (tmr_done) begin
					nxt_st   = ST_ACTIVE;
					nxt_mode = M_RUN;
				end
			end
			default: begin
				nxt_st   = ST_ACTIVE;
				nxt_mode = M_RUN;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_ff   <= ST_ACTIVE;
			mode_ff <= M_RUN;
		end else begin
			st_ff   <= nxt_st;
			mode_ff <= nxt_mode;
		end
	end

	wake_timer u_wake_timer (
		.clock    (clock),
		.rst_b    (rst_b),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done)
	);

	// power, clock and pull outputs, registered with the mode
	logic halt_ff, lpr_ff, frz_ff, lpt2_ff, fl_ff, msr_ff, rsr_ff;
	logic asr_ff, mclk_ff, sclk_ff, xtal_ff, hsi_ff;
	logic nxt_halt, nxt_lpr, nxt_frz, nxt_lpt2, nxt_fl, nxt_msr;
	logic nxt_rsr, nxt_asr, nxt_mclk, nxt_sclk, nxt_xtal, nxt_hsi;
	logic [`OSC_REQ_W-1:0] feed_ff, nxt_feed;
	logic [`WK_W-1:0]      wken_ff, nxt_wken;
	pull_t                 pull_ff, nxt_pull;

	always_comb begin
		nxt_halt = (nxt_mode > M_LOW_POWER_RUN) || (nxt_st == ST_WAKE);
		nxt_lpr  = (nxt_mode == M_LOW_POWER_RUN) || (nxt_mode == M_LOW_POWER_SLEEP) ||
			(nxt_mode == M_STOP1) || (nxt_mode == M_DEEPEST_STOP_LEVEL) ||
			(nxt_mode == M_STANDBY);
		nxt_frz  = (nxt_mode >= M_STOP0);
		nxt_lpt2 = (nxt_mode <= M_STOP1);
		// optional flash power-down only with the radio idle
		nxt_fl   = (nxt_mode <= M_LOW_POWER_SLEEP) &&
			!(flash_pd_cfg && !radio_active &&
			(nxt_mode == M_RUN || nxt_mode == M_SLEEP));
		nxt_msr  = (nxt_mode <= M_DEEPEST_STOP_LEVEL);
		nxt_asr  = (nxt_mode <= M_DEEPEST_STOP_LEVEL);
		if (nxt_mode <= M_DEEPEST_STOP_LEVEL) begin
			nxt_rsr = 1'b1;
		end else if (nxt_mode == M_STANDBY) begin
			nxt_rsr = sram_retain_select;
		end else begin
			nxt_rsr = 1'b0;
		end
		// memory clocks stop in stop levels; gateable while asleep
		nxt_mclk = (nxt_mode <= M_LOW_POWER_SLEEP) &&
			!(is_sleep(nxt_mode) && main_sram_clk_gate);
		nxt_sclk = (nxt_mode <= M_LOW_POWER_SLEEP) &&
			!(is_sleep(nxt_mode) && second_sram_clk_gate);
		nxt_xtal = radio_txrx_need && (nxt_mode <= M_STOP1);
		// oscillator runs only while some peripheral asks for it
		nxt_hsi  = (|osc_req) && (nxt_mode <= M_STOP1);
		nxt_feed = nxt_hsi ? osc_req : `OSC_FEED_NONE;
		nxt_wken = wake_mask(nxt_mode);
		// pulls caught on entry, dropped as soon as the mode ends
		if (nxt_mode == M_STANDBY || nxt_mode == M_SHUTDOWN) begin
			nxt_pull = (mode_ff == nxt_mode) ? pull_ff : io_pull_cfg;
		end else begin
			nxt_pull = PULL_FLOAT;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			halt_ff <= 1'b0;
			lpr_ff  <= 1'b0;
			frz_ff  <= 1'b0;
			lpt2_ff <= 1'b1;
			fl_ff   <= 1'b1;
			msr_ff  <= 1'b1;
			rsr_ff  <= 1'b1;
			asr_ff  <= 1'b1;
			mclk_ff <= 1'b1;
			sclk_ff <= 1'b1;
			xtal_ff <= 1'b0;
			hsi_ff  <= 1'b0;
			feed_ff <= `OSC_FEED_NONE;
			wken_ff <= `WKM_NONE;
			pull_ff <= PULL_FLOAT;
		end else begin
			halt_ff <= nxt_halt;
			lpr_ff  <= nxt_lpr;
			frz_ff  <= nxt_frz;
			lpt2_ff <= nxt_lpt2;
			fl_ff   <= nxt_fl;
			msr_ff  <= nxt_msr;
			rsr_ff  <= nxt_rsr;
			asr_ff  <= nxt_asr;
			mclk_ff <= nxt_mclk;
			sclk_ff <= nxt_sclk;
			xtal_ff <= nxt_xtal;
			hsi_ff  <= nxt_hsi;
			feed_ff <= nxt_feed;
			wken_ff <= nxt_wken;
			pull_ff <= nxt_pull;
		end
	end

	// wake interrupts and flash programming answers
	logic swk_ff, iwk_ff, fack_ff, fref_ff;
	logic nxt_swk, nxt_iwk, nxt_fack, nxt_fref;

	always_comb begin
		nxt_swk  = is_stop01(mode_ff) && wk_all[`WK_SERIAL];
		nxt_iwk  = is_stop01(mode_ff) && i2c_addr_match;
		// low-power run and every halted mode refuse programming
		nxt_fack = flash_prog_req && (mode_ff == M_RUN) &&
			(st_ff == ST_ACTIVE);
		nxt_fref = flash_prog_req && !nxt_fack;
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			swk_ff  <= 1'b0;
			iwk_ff  <= 1'b0;
			fack_ff <= 1'b0;
			fref_ff <= 1'b0;
		end else begin
			swk_ff  <= nxt_swk;
			iwk_ff  <= nxt_iwk;
			fack_ff <= nxt_fack;
			fref_ff <= nxt_fref;
		end
	end

	assign power_mode                = mode_ff;
	assign host_core_halted          = halt_ff;
	assign regulator_low_power       = lpr_ff;
	assign periph_frozen             = frz_ff;
	assign lptim2_enabled            = lpt2_ff;
	assign flash_powered             = fl_ff;
	assign main_sram_bank_pwr        = msr_ff;
	assign retained_sram_bank_pwr    = rsr_ff;
	assign auxiliary_sram_bank_pwr   = asr_ff;
	assign main_sram_clk_en          = mclk_ff;
	assign second_sram_clk_en        = sclk_ff;
	assign radio_crystal_osc_en      = xtal_ff;
	assign on_demand_internal_osc_en = hsi_ff;
	assign osc_feed                  = feed_ff;
	assign wake_enable               = wken_ff;
	assign serial_wake_irq           = swk_ff;
	assign i2c_wake_irq              = iwk_ff;
	assign io_pull_hold              = pull_ff;
	assign flash_prog_ack            = fack_ff;
	assign flash_prog_refused        = fref_ff;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence seq_sleep_wake;
		(st_ff == ST_LOW) && is_sleep(mode_ff) && irq_any;
	endsequence

	sequence seq_back_to_run;
		(mode_ff != M_RUN) [*8] ##1
		((mode_ff == M_RUN) && !host_core_halted);
	endsequence

	chk_sleep_wake_time: assert property (
		seq_sleep_wake |=> seq_back_to_run)
		else $error("sleep wake latency wrong");
	chk_radio_depth_cap: assert property (
		(st_ff == ST_ACTIVE && host_mode_valid && radio_active)
		|=> (mode_ff <= M_DEEPEST_STOP_LEVEL))
		else $error("radio active but mode too deep");
	chk_stop_flash_off: assert property (
		(mode_ff >= M_STOP0) |-> !flash_powered && periph_frozen)
		else $error("flash on or peripherals live in stop");
	chk_retain_follows_bit: assert property (
		(mode_ff == M_STANDBY) |->
		(retained_sram_bank_pwr == $past(sram_retain_select)))
		else $error("retained bank ignores select");
	chk_standby_banks_off: assert property (
		(mode_ff >= M_STANDBY) |->
		!main_sram_bank_pwr && !auxiliary_sram_bank_pwr)
		else $error("main or aux bank powered in standby");
	chk_osc_release: assert property (
		(osc_req == `OSC_FEED_NONE) |=> !on_demand_internal_osc_en)
		else $error("on-demand oscillator left running");
	chk_serial_wake_irq: assert property (
		(is_stop01(mode_ff) && serial_frame_done) |=> serial_wake_irq)
		else $error("serial wake interrupt missing");
	chk_i2c_wake_irq: assert property (
		(is_stop01(mode_ff) && i2c_addr_match) |=> i2c_wake_irq)
		else $error("i2c wake interrupt missing");
	chk_flash_prog_low_power_run: assert property (
		(flash_prog_req && mode_ff == M_LOW_POWER_RUN) |=>
		flash_prog_refused && !flash_prog_ack)
		else $error("flash programming taken in low-power run");
	chk_pull_discard: assert property (
		($past(mode_ff) == M_SHUTDOWN && mode_ff != M_SHUTDOWN)
		|-> (io_pull_hold == PULL_FLOAT))
		else $error("shutdown pulls survive exit");
	chk_xtal_for_radio: assert property (
		// crystal follows the need one cycle later, so the need must
		// already have stood in the previous cycle
		(radio_txrx_need && $past(radio_txrx_need) &&
		mode_ff <= M_STOP1 && $stable(mode_ff))
		|-> radio_crystal_osc_en)
		else $error("radio crystal not enabled");

endmodule : low_power_mode_controller

// [test/radio_model.sv]
// behavioural radio subsystem seen by the mode controller
`timescale 1ns/1ps

module radio_model (
	input  wire logic           clock,
	input  wire logic           rst_b,
	input  wire logic           radio_use,
	input  wire logic           halt_radio,
	input  wire lpm_pkg::mode_t radio_want,
	output lpm_pkg::mode_t      radio_mode_req,
	output logic                radio_active,
	output logic                radio_txrx_need
);
	import lpm_pkg::*;

	// firmware-like: levels move only just after an edge
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			// idle radio puts no limit on depth
			radio_mode_req  <= M_SHUTDOWN;
			radio_active    <= 1'h0;
			radio_txrx_need <= 1'h0;
		end else begin
			// halt_radio stops traffic; active and need drop at the next edge
			radio_active    <= radio_use & ~halt_radio;
			radio_txrx_need <= radio_use & ~halt_radio;
			radio_mode_req  <= radio_want;
		end
	end
endmodule : radio_model

// [test/tb.sv]
// self-checking bench for the low power mode controller
`timescale 1ns/1ps
`include "lpm_consts.svh"

module tb;
	import lpm_pkg::*;

	logic	clock = 1'h0;
	logic	rst_b, host_mode_valid, irq_any, flash_pd_cfg;
	logic	sram_retain_select, flash_prog_req, radio_use, halt_radio;
	logic	main_sram_clk_gate, second_sram_clk_gate;
	logic	radio_active, radio_txrx_need;
	logic	[3:0] ev; // serial start, addr, frame, i2c match
	logic	[`WK_W-1:0] wake_src, wake_enable;
	logic	[`OSC_REQ_W-1:0] osc_req, osc_feed;
	mode_t	host_mode_req, radio_mode_req, radio_want, power_mode;
	pull_t	io_pull_cfg, io_pull_hold;
	logic	host_core_halted, regulator_low_power, periph_frozen;
	logic	lptim2_enabled, flash_powered, main_sram_bank_pwr;
	logic	retained_sram_bank_pwr, auxiliary_sram_bank_pwr;
	logic	main_sram_clk_en, second_sram_clk_en;
	logic	radio_crystal_osc_en, on_demand_internal_osc_en;
	logic	serial_wake_irq, i2c_wake_irq;
	logic	flash_prog_ack, flash_prog_refused;
	int	failures = 0;
	int	checked = 0;

	always #5 clock = ~clock;

	low_power_mode_controller low_power_mode_controller_i (
		.clock, .rst_b, .host_mode_valid, .host_mode_req,
		.radio_mode_req, .radio_active, .radio_txrx_need, .irq_any,
		.wake_src, .serial_start_bit(ev[0]), .serial_addr_match(ev[1]),
		.serial_frame_done(ev[2]), .i2c_addr_match(ev[3]), .osc_req,
		.sram_retain_select, .flash_pd_cfg, .main_sram_clk_gate,
		.second_sram_clk_gate, .io_pull_cfg, .flash_prog_req,
		.power_mode, .host_core_halted, .regulator_low_power,
		.periph_frozen, .lptim2_enabled, .flash_powered,
		.main_sram_bank_pwr, .retained_sram_bank_pwr,
		.auxiliary_sram_bank_pwr, .main_sram_clk_en,
		.second_sram_clk_en, .radio_crystal_osc_en,
		.on_demand_internal_osc_en, .osc_feed, .wake_enable,
		.serial_wake_irq, .i2c_wake_irq, .io_pull_hold,
		.flash_prog_ack, .flash_prog_refused
	);

	radio_model radio_model_i (
		.clock, .rst_b, .radio_use, .halt_radio, .radio_want,
		.radio_mode_req, .radio_active, .radio_txrx_need
	);

	// one compare, mismatch reported at once
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	task automatic ended(input string name);
		$display("test %s done", name);
	endtask : ended

	// one-cycle entry request from host software
	task automatic enter(input mode_t m);
		@(negedge clock);
		host_mode_req = m;
		host_mode_valid = 1'h1;
		@(negedge clock);
		host_mode_valid = 1'h0;
	endtask : enter

	// count edges back to run; bounded so a hang ends the run
	task automatic wait_run(input int exp);
		int n;
		n = 0;
		while (power_mode !== M_RUN) begin
			@(negedge clock);
			n++;
			if (n > 40) begin
				failures++;
				final_report();
			end
		end
		check("wake latency", n[15:0], exp[15:0]);
	endtask : wait_run

	// a source outside the mode mask must leave the mode alone
	task automatic no_wake(input int idx, input mode_t m);
		@(negedge clock);
		wake_src[idx] = 1'h1;
		repeat (3) @(negedge clock);
		check("ignored source", power_mode, m);
		wake_src = 13'h0;
	endtask : no_wake

	task automatic wake(input int idx, input int exp);
		@(negedge clock);
		wake_src[idx] = 1'h1;
		wait_run(exp);
		wake_src = 13'h0;
	endtask : wake

	// programming pulse, answer one cycle later
	task automatic prog(input logic [1:0] exp);
		@(negedge clock);
		flash_prog_req = 1'h1;
		@(negedge clock);
		flash_prog_req = 1'h0;
		check("prog answer", {flash_prog_ack, flash_prog_refused}, exp);
	endtask : prog

	task automatic t_reset;
		check("reset mode", power_mode, M_RUN);
		check("reset mask", wake_enable, `WKM_NONE);
		check("reset pulls", io_pull_hold, PULL_FLOAT);
		check("reset memories", {flash_powered, main_sram_bank_pwr,
			retained_sram_bank_pwr, auxiliary_sram_bank_pwr}, 16'h000f);
		ended("reset");
	endtask : t_reset

	task automatic t_flash;
		prog(2'h2);
		enter(M_LOW_POWER_RUN);
		check("low_power_run regulator", regulator_low_power, 1'h1);
		prog(2'h1);
		enter(M_RUN);
		flash_pd_cfg = 1'h1;
		repeat (2) @(negedge clock);
		check("flash power-down", flash_powered, 1'h0);
		flash_pd_cfg = 1'h0;
		ended("flash");
	endtask : t_flash

	task automatic t_sleep;
		for (int i = 0; i < 2; i++) begin
			// gate one bank clock, then the other
			main_sram_clk_gate = i[0];
			second_sram_clk_gate = ~i[0];
			enter(i[0] ? M_LOW_POWER_SLEEP : M_SLEEP);
			check("sleep halt", host_core_halted, 1'h1);
			check("sram clocks", {main_sram_clk_en, second_sram_clk_en},
				{~i[0], i[0]});
			irq_any = 1'h1;
			wait_run(9);
			irq_any = 1'h0;
			check("core running", host_core_halted, 1'h0);
		end
		main_sram_clk_gate = 1'h0;
		second_sram_clk_gate = 1'h0;
		ended("sleep");
	endtask : t_sleep

	task automatic t_deepest_stop_level;
		radio_use = 1'h1;
		enter(M_STANDBY);
		check("radio depth cap", power_mode, M_DEEPEST_STOP_LEVEL);
		check("deepest_stop_level mask", wake_enable, `WKM_DEEPEST_STOP_LEVEL);
		check("deepest_stop_level domains", {flash_powered, main_sram_bank_pwr,
			periph_frozen, lptim2_enabled}, 16'h0006);
		no_wake(`WK_LPTIM2, M_DEEPEST_STOP_LEVEL);
		wake(`WK_RTC, 16);
		radio_use = 1'h0;
		ended("deepest_stop_level");
	endtask : t_deepest_stop_level

	task automatic t_stop_wake;
		radio_use = 1'h1;
		radio_want = M_STOP1;
		osc_req = 2'h2;
		for (int k = 0; k < 4; k++) begin
			// shallower of host and radio wins
			enter(k[0] ? M_DEEPEST_STOP_LEVEL : M_STOP0);
			check("arbitration", power_mode,
				k[0] ? M_STOP1 : M_STOP0);
			check("stop mask", wake_enable, `WKM_STOP01);
			check("crystal", radio_crystal_osc_en, 1'h1);
			check("osc feed", {on_demand_internal_osc_en, osc_feed},
				16'h0006);
			ev[k] = 1'h1;
			@(negedge clock);
			ev = 4'h0;
			check("wake irq", {i2c_wake_irq, serial_wake_irq},
				(k == 3) ? 16'h0002 : 16'h0001);
			wait_run(15);
		end
		osc_req = 2'h0;
		radio_use = 1'h0;
		radio_want = M_SHUTDOWN;
		repeat (2) @(negedge clock);
		check("osc off", {on_demand_internal_osc_en, osc_feed},
			16'h0000);
		ended("stop wake");
	endtask : t_stop_wake

	task automatic t_standby;
		halt_radio = 1'h1;
		for (int s = 0; s < 2; s++) begin
			sram_retain_select = s[0];
			io_pull_cfg = s[0] ? PULL_UP : PULL_DOWN;
			enter(M_STANDBY);
			check("retained bank", retained_sram_bank_pwr, s[0]);
			check("other banks", {main_sram_bank_pwr,
				auxiliary_sram_bank_pwr}, 16'h0000);
			check("held pulls", io_pull_hold, io_pull_cfg);
			no_wake(`WK_ANY_IO, M_STANDBY);
			wake(`WK_PIN0, 16);
			check("pulls out", io_pull_hold, PULL_FLOAT);
		end
		io_pull_cfg = PULL_UP;
		enter(M_SHUTDOWN);
		check("shutdown pulls", io_pull_hold, PULL_UP);
		no_wake(`WK_RADIO, M_SHUTDOWN);
		wake(`WK_PIN1, 16);
		check("pulls lost", io_pull_hold, PULL_FLOAT);
		halt_radio = 1'h0;
		ended("standby");
	endtask : t_standby

	initial begin
		rst_b = 1'h0;
		host_mode_valid = 1'h0;
		host_mode_req = M_RUN;
		radio_want = M_SHUTDOWN;
		{radio_use, halt_radio, irq_any, flash_pd_cfg} = 4'h0;
		{sram_retain_select, flash_prog_req} = 2'h0;
		{main_sram_clk_gate, second_sram_clk_gate} = 2'h0;
		ev = 4'h0;
		wake_src = 13'h0;
		osc_req = 2'h0;
		io_pull_cfg = PULL_FLOAT;
		repeat (2) @(negedge clock);
		rst_b = 1'h1;
		t_reset();
		t_flash();
		t_sleep();
		t_deepest_stop_level();
		t_stop_wake();
		t_standby();
		final_report();
	end
endmodule : tb
